// File: wdog_map.vh
// Constants for the output-14 hardware watchdog.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef WDOG_MAP_VH
`define WDOG_MAP_VH
`define CLK_HZ 10000000
`define TIMEOUT_MS 5000
`define STARTUP_MS 1000
`define MS_PER_S 1000
`define TICK_HZ 1000
`define CNT_W 16
`define SYNC_STAGES 3
`define DIV_W 32
`define PIN_SEL 0
`define PIN_REF 1
`define PIN_PG 2
`define PIN_N 3
`endif

// File: pin_sync.v
// Three-stage synchroniser with agreement check for one pin input.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/10ps
module pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk_sys,
  input wire rst,
  input wire pin_in,
  output reg level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      level_r <= RESET_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Only a value seen on two later stages counts as a change
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule

// File: hardware_watchdog_output.v
// Hardware watchdog that can take over output 14 on its terminal.
// Assumes refresh, power-good and selector are asynchronous pins; function level is local.
// The three pins pass one filter bank; out14_function is taken straight on clk_sys.
`timescale 1ns/10ps
`include "wdog_map.vh"

module hardware_watchdog_output #(
  parameter TICK_DIV = `CLK_HZ / `TICK_HZ,
  parameter TIMEOUT_TICKS = `TIMEOUT_MS * `TICK_HZ / `MS_PER_S,
  parameter STARTUP_TICKS = `STARTUP_MS * `TICK_HZ / `MS_PER_S
) (
  input wire clk_sys,
  input wire rst,
  input wire watchdog_route_selector,
  input wire wdog_refresh,
  input wire power_good,
  input wire out14_function,
  output reg output14_terminal,
  output reg wdog_active_r
);
  localparam ST_START = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_FAIL = 3'b100;

  // Pins read as released until filtered, so selector and refresh stay off and power reads as lost during the sync delay
  localparam PIN_RESET = 1'b0;

  // Compare points cut to the counter widths on purpose
  localparam [`DIV_W-1:0] TICK_LAST = TICK_DIV - 1;
  localparam [`DIV_W-1:0] STARTUP_LAST_W = STARTUP_TICKS - 1;
  localparam [`DIV_W-1:0] TIMEOUT_W = TIMEOUT_TICKS;
  localparam [`CNT_W-1:0] STARTUP_LAST = STARTUP_LAST_W[`CNT_W-1:0];
  localparam [`CNT_W-1:0] TIMEOUT_LAST = TIMEOUT_W[`CNT_W-1:0];
  localparam [`CNT_W-1:0] CNT_MAX = {`CNT_W{1'b1}};
  localparam [`CNT_W-1:0] CNT_ZERO = {`CNT_W{1'b0}};
  localparam [`CNT_W-1:0] CNT_ONE = {{(`CNT_W-1){1'b0}}, 1'b1};

  localparam [`DIV_W-1:0] DIV_ZERO = {`DIV_W{1'b0}};
  localparam [`DIV_W-1:0] DIV_ONE = {{(`DIV_W-1){1'b0}}, 1'b1};

  wire [`PIN_N-1:0] pin_raw;
  wire [`PIN_N-1:0] pin_lvl;
  wire sel_s;
  wire refresh_s;
  wire pgood_s;
  wire power_lost;

  reg refresh_d_r;
  wire refresh_edge;
  wire refresh_take;
  reg [`DIV_W-1:0] div_r;
  reg [`DIV_W-1:0] div_nxt;
  reg tick_r;
  reg tick_nxt;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  wire in_start;
  wire in_run;
  wire startup_done;
  wire timeout_hit;

  reg [`CNT_W-1:0] cnt_r;
  reg [`CNT_W-1:0] cnt_nxt;
  wire cnt_clear;
  wire cnt_step;
  wire run_nxt;
  reg terminal_nxt;

  // All three pins are asynchronous to clk_sys, so each gets the same filter
  assign pin_raw[`PIN_SEL] = watchdog_route_selector;
  assign pin_raw[`PIN_REF] = wdog_refresh;
  assign pin_raw[`PIN_PG] = power_good;

  genvar gi;
  generate
    for (gi = 0; gi < `PIN_N; gi = gi + 1) begin : g_pin
      pin_sync #(
        .RESET_VAL(PIN_RESET)
      ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(pin_raw[gi]),
        .level_r(pin_lvl[gi])
      );
    end
  endgenerate

  assign sel_s = pin_lvl[`PIN_SEL];
  assign refresh_s = pin_lvl[`PIN_REF];
  assign pgood_s = pin_lvl[`PIN_PG];
  assign power_lost = ~pgood_s;

  // A refresh is a rising edge so a stuck-high line cannot keep the dog fed
  assign refresh_edge = refresh_s & ~refresh_d_r;
  // Refreshes outside the run state are ignored: they must not stretch start-up
  assign refresh_take = refresh_edge & in_run;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      refresh_d_r <= 1'b0;
    end else begin
      refresh_d_r <= refresh_s;
    end
  end

  // Millisecond tick enable; every slower count advances only on it
  always @* begin
    div_nxt = div_r + DIV_ONE;
    tick_nxt = 1'b0;
    if (div_r == TICK_LAST) begin
      div_nxt = DIV_ZERO;
      tick_nxt = 1'b1;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_r <= DIV_ZERO;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign in_start = (state_r == ST_START);
  assign in_run = (state_r == ST_RUN);

  assign startup_done = in_start & tick_r & (cnt_r >= STARTUP_LAST);
  // Failing only on the tick after the full count keeps the starve time strictly longer
  assign timeout_hit = in_run & tick_r & (cnt_r >= TIMEOUT_LAST) & ~refresh_take;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_START: begin
        if (startup_done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (timeout_hit) begin
          state_nxt = ST_FAIL;
        end
      end
      ST_FAIL: begin
        // Latched until power drops or reset, so a late refresh cannot revive it
        state_nxt = ST_FAIL;
      end
      default: begin
        state_nxt = ST_START;
      end
    endcase
    // Power loss overrides every state and restarts the start-up delay
    if (power_lost) begin
      state_nxt = ST_START;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_START;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The count sits at zero while power is down, so start-up is timed from its return
  assign cnt_clear = power_lost | (state_nxt != state_r) | refresh_take;
  assign cnt_step = tick_r & (cnt_r != CNT_MAX);

  always @* begin
    cnt_nxt = cnt_r;
    if (cnt_clear) begin
      cnt_nxt = CNT_ZERO;
    end else if (cnt_step) begin
      cnt_nxt = cnt_r + CNT_ONE;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Power is checked again so the output drops in the very cycle it is seen lost
  assign run_nxt = (state_nxt == ST_RUN) & pgood_s;

  // Selector on hands the terminal to the watchdog whatever the function asks
  always @* begin
    if (sel_s) begin
      terminal_nxt = run_nxt;
    end else begin
      terminal_nxt = out14_function;
    end
  end

  // Terminal level 1 means the driver pulls to battery negative
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      output14_terminal <= 1'b0;
    end else begin
      output14_terminal <= terminal_nxt;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdog_active_r <= 1'b0;
    end else begin
      wdog_active_r <= run_nxt;
    end
  end
endmodule

// File: wdog_asserts.sv
// Port checker for the watchdog, bound to each instance.
// Assumes the instance runs with the small simulation counts.
`timescale 1ns/10ps
module wdog_asserts #(parameter TICK_DIV = 4, TIMEOUT_TICKS = 20, STARTUP_TICKS = 4) (
  input wire clk_sys, rst, watchdog_route_selector, wdog_refresh,
  input wire power_good, out14_function, output14_terminal, wdog_active_r
);
  localparam int TO = TIMEOUT_TICKS * TICK_DIV;
  localparam int SU = STARTUP_TICKS * TICK_DIV;
  wire s = watchdog_route_selector, t = output14_terminal, a = wdog_active_r;
  logic [15:0] idle_r, up_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Idle time counts only while the dog runs, since a restart forgets the old timeout
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) {idle_r, up_r} <= 32'h0;
    else begin
      idle_r <= (wdog_refresh || !power_good || !a) ? 16'h0 : idle_r + 16'h1;
      up_r <= up_r + 16'h1;
    end
  property p_fn; !s [*6] |-> t == $past(out14_function); endproperty
  a_fn: assert property (p_fn) else $error("fn");
  property p_on; s [*6] ##0 a [*3] |-> t; endproperty
  a_on: assert property (p_on) else $error("on");
  property p_blk; s [*6] ##0 !a [*3] |-> !t; endproperty
  a_blk: assert property (p_blk) else $error("blk");
  property p_pwr; !power_good [*6] |-> !a; endproperty
  a_pwr: assert property (p_pwr) else $error("pwr");
  property p_to; idle_r > TO + TICK_DIV + 10 |-> !a; endproperty
  a_to: assert property (p_to) else $error("to");
  property p_keep; power_good [*6] ##0 (a && idle_r < TO - TICK_DIV - 2) |=> a; endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_early; up_r < SU - TICK_DIV |-> !a; endproperty
  a_early: assert property (p_early) else $error("early");
  property p_late; up_r == SU + TICK_DIV + 10 |-> a; endproperty
  a_late: assert property (p_late) else $error("late");
endmodule
bind hardware_watchdog_output wdog_asserts #(.TICK_DIV(TICK_DIV),
  .TIMEOUT_TICKS(TIMEOUT_TICKS), .STARTUP_TICKS(STARTUP_TICKS)) u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .watchdog_route_selector(watchdog_route_selector),
  .wdog_refresh(wdog_refresh),
  .power_good(power_good),
  .out14_function(out14_function),
  .output14_terminal(output14_terminal),
  .wdog_active_r(wdog_active_r)
);

// File: wdog_load.sv
// Relay wired to the output-14 terminal.
// The contacts follow coil_r one clock late, and the terminal two clocks late, like a slow armature.
`timescale 1ns/10ps
module wdog_load (
  input wire clk_sys,
  input wire output14_terminal,
  output reg relay_closed_r = 1'b0
);
  reg coil_r = 1'b0;
  always @(posedge clk_sys) {relay_closed_r, coil_r} <= {coil_r, output14_terminal};
endmodule

// File: tb.sv
// Bench for the watchdog: scenario tasks drive pins at falling edges.
// Assumes the bound checker and the relay model.
`timescale 1ns/10ps
module tb;
  reg clk_sys = 0, rst = 1, sel = 1, rf = 0, pg = 1, fn = 0;
  wire t, a, rl;
  wire [2:0] o = {t, a, rl};
  integer failures = 0, compares = 0;
  always #50 clk_sys = ~clk_sys;
  hardware_watchdog_output #(.TICK_DIV(4), .TIMEOUT_TICKS(20), .STARTUP_TICKS(4)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .watchdog_route_selector(sel), .wdog_refresh(rf),
    .power_good(pg), .out14_function(fn), .output14_terminal(t), .wdog_active_r(a));
  wdog_load u_load (.clk_sys(clk_sys), .output14_terminal(t), .relay_closed_r(rl));
  task w(input integer n); repeat (n) @(negedge clk_sys); endtask
  task chk(input [2:0] v, input [2:0] e);
    compares = compares + 1;
    if (v !== e) begin
      failures = failures + 1;
      $display("MISMATCH %0t %h %h", $time, v, e);
    end
  endtask
  task give_verdict;
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task t_start;
    w(8);
    chk(o, 3'h0);
    w(26);
    chk(o, 3'h7);
  endtask
  // Refresh pulses are four clocks wide so the pin filter cannot drop them
  task t_ref;
    repeat (4) begin
      rf = 1;
      w(4);
      rf = 0;
      w(36);
    end
    chk(o, 3'h7);
  endtask
  task t_fail;
    fn = 1;
    w(100);
    chk(o, 3'h0);
    chk({t, fn, rl}, 3'h2);
  endtask
  task t_off;
    sel = 0;
    w(10);
    chk(o, 3'h5);
    fn = 0;
    w(10);
    chk(o, 3'h0);
  endtask
  task t_pwr;
    sel = 1;
    pg = 0;
    w(10);
    pg = 1;
    w(12);
    chk(o, 3'h0);
    w(22);
    chk(o, 3'h7);
    pg = 0;
    w(10);
    chk(o, 3'h0);
  endtask
  initial begin
    #100000;
    failures = failures + 1;
    give_verdict;
  end
  initial begin
    w(8);
    rst = 0;
    t_start;
    t_ref;
    t_fail;
    t_off;
    t_pwr;
    give_verdict;
  end
endmodule
